// ### pkg/mrcs_cfg.svh
// How it works
// - One-hot size field sets block, four quarters
// - Selector one: selects; zero: latched a1, a2
// - Space bit: one memory, zero I/O cycles
// - Upper selects: ready bit zero waits ready
// - Aux wait field adds 0-3 upper waits
// - Upper pins high until aux register access
// - Upper pins need no peripheral base write
// - Midrange selects need both registers written
// - Base field gives address bits 19-13
// - Midrange selects assert one cycle after address latch, AD timing
// - Midrange ready bit zero waits external ready
// - Midrange wait field adds 0-3 waits
`ifndef MRCS_CFG_SVH
`define MRCS_CFG_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define MRCS_IDX_MID_BASE   12'h0A6
`define MRCS_IDX_AUX        12'h0A8
`define MRCS_IDX_STATUS     12'h0AA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MRCS_BASE_MSB       15
`define MRCS_BASE_LSB       9
`define MRCS_SIZE_MSB       14
`define MRCS_SIZE_LSB       8
`define MRCS_PINSEL_BIT     7
`define MRCS_SPACE_BIT      6
`define MRCS_RDY_BIT        2
`define MRCS_WS_MSB         1
`define MRCS_WS_LSB         0

// ----------------------------------------------------------------
// Reset values and fixed read-back bits
// ----------------------------------------------------------------
`define MRCS_RST_BASE       7'h00
`define MRCS_RST_SIZE       7'h00
`define MRCS_RST_WS         2'h0
`define MRCS_MID_ONES       16'h01F8
`define MRCS_AUX_ONES       16'h8038

// ----------------------------------------------------------------
// Peripheral select windows, in 256-byte units above the base
// ----------------------------------------------------------------
`define MRCS_PCS5_SLOT      12'h005
`define MRCS_PCS6_SLOT      12'h006

`endif

// ### pkg/mrcs_pkg.sv
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package mrcs_pkg;

  // Bus cycle tracking
  typedef enum logic [1:0] {
    CS_IDLE   = 2'b00,
    CS_ADDR   = 2'b01,
    CS_ACTIVE = 2'b10
  } mrcs_state_t;

  // AXI4-Lite response codes
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } mrcs_resp_t;

endpackage : mrcs_pkg

// ### core/mrcs_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Three-stage pin synchroniser, output moves when stages 2 and 3 agree
// ----------------------------------------------------------------
module mrcs_sync3 (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin,
  output var  logic level
);
  logic s1;
  logic s2;
  logic s3;

  // Stage one feeds stage two only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule : mrcs_sync3
`default_nettype wire

// ### core/mrcs_wait_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Wait-state counter with optional external ready
// ----------------------------------------------------------------
module mrcs_wait_cnt (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [1:0] wait_states,
  input  wire logic       ready_mode,
  input  wire logic       ext_ready,
  input  wire logic       busy,
  output var  logic       done
);
  logic [1:0] count;
  logic       ignore_rdy;

  // Reload at select assertion, then count down to zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count      <= 2'h0;
      ignore_rdy <= 1'b0;
    end else if (load) begin
      count      <= wait_states;
      ignore_rdy <= ready_mode;
    end else if (count != 2'h0) begin
      count <= count - 2'h1;
    end
  end

  // Count applies in both ready modes
  assign done = busy && (count == 2'h0) && (ignore_rdy || ext_ready);
endmodule : mrcs_wait_cnt
`default_nettype wire

// ### core/mrcs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrcs_cfg.svh"
// ----------------------------------------------------------------
// Midrange and upper peripheral chip-select decode
// ----------------------------------------------------------------
module mrcs_top (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AXI4-Lite register port
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Processor bus side
  input  wire logic [19:0] cpu_addr,
  input  wire logic        cpu_cycle_start,
  input  wire logic        cpu_is_mem,
  input  wire logic [8:0]  periph_base,
  input  wire logic        ext_ready_pin,
  output var  logic [3:0]  midrange_select_outputs_n,
  output var  logic [1:0]  upper_peripheral_selects_n,
  output var  logic        cs_claim,
  output var  logic        cs_ready
);

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_MID = 12'(`MRCS_IDX_MID_BASE * 4);
  localparam logic [11:0] ADDR_AUX = 12'(`MRCS_IDX_AUX * 4);
  localparam logic [11:0] ADDR_STA = 12'(`MRCS_IDX_STATUS * 4);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [6:0]  block_base_field;
  logic        mid_ready_mode;
  logic [1:0]  mid_wait_field;
  logic [6:0]  block_size_field;
  logic        pin_function_selector;
  logic        space_selector;
  logic        aux_ready_mode;
  logic [1:0]  aux_wait_field;
  logic        mid_written;
  logic        aux_written;
  logic        upper_active;

  // AXI holding state
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0]  w_strb;

  // Bus cycle state
  mrcs_pkg::mrcs_state_t state;
  mrcs_pkg::mrcs_state_t next_state;
  logic [19:0] cyc_addr;
  logic        cyc_mem;
  logic        cur_is_mid;
  logic        cur_rmode;
  logic [1:0]  cur_ws;
  logic [1:0]  act_cnt;
  logic        ext_ready_s;
  logic        wait_done;

  // ----------------------------------------------------------------
  // AXI write and read decode
  // ----------------------------------------------------------------
  wire wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire wr_mid    = wr_go && (aw_addr == ADDR_MID);
  wire wr_aux    = wr_go && (aw_addr == ADDR_AUX);
  wire wr_sta    = wr_go && (aw_addr == ADDR_STA);
  wire wr_ok     = wr_mid || wr_aux || wr_sta;
  wire rd_go     = s_axi_arvalid && s_axi_arready;
  wire rd_aux    = rd_go && (s_axi_araddr == ADDR_AUX);
  wire [15:0] mid_rd = `MRCS_MID_ONES | {block_base_field, 6'h00,
                       mid_ready_mode, mid_wait_field};
  wire [15:0] aux_rd = `MRCS_AUX_ONES | {1'b0, block_size_field,
                       pin_function_selector, space_selector, 3'h0,
                       aux_ready_mode, aux_wait_field};
  wire [15:0] sta_rd = {8'h00, 2'(state), upper_active, aux_written,
                        mid_written, cs_claim,
                        upper_peripheral_selects_n == 2'b11,
                        midrange_select_outputs_n == 4'hF};

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Address and data may arrive in either order
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 16'h0000;
      w_strb  <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[15:0];
        w_strb <= s_axi_wstrb[1:0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, unmapped address answers SLVERR
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mrcs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? mrcs_pkg::RESP_OKAY : mrcs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data, upper sixteen bits read zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= mrcs_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mrcs_pkg::RESP_OKAY;
      if (s_axi_araddr == ADDR_MID) begin
        s_axi_rdata <= {16'h0000, mid_rd};
      end else if (s_axi_araddr == ADDR_AUX) begin
        s_axi_rdata <= {16'h0000, aux_rd};
      end else if (s_axi_araddr == ADDR_STA) begin
        s_axi_rdata <= {16'h0000, sta_rd};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= mrcs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Byte lanes: lane 1 holds base and size, lane 0 the mode bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      block_base_field      <= `MRCS_RST_BASE;
      mid_ready_mode        <= 1'b0;
      mid_wait_field        <= `MRCS_RST_WS;
      block_size_field      <= `MRCS_RST_SIZE;
      pin_function_selector <= 1'b0;
      space_selector        <= 1'b0;
      aux_ready_mode        <= 1'b0;
      aux_wait_field        <= `MRCS_RST_WS;
    end else begin
      if (wr_mid && w_strb[1]) begin
        block_base_field <= w_data[`MRCS_BASE_MSB:`MRCS_BASE_LSB];
      end
      if (wr_mid && w_strb[0]) begin
        mid_ready_mode <= w_data[`MRCS_RDY_BIT];
        mid_wait_field <= w_data[`MRCS_WS_MSB:`MRCS_WS_LSB];
      end
      if (wr_aux && w_strb[1]) begin
        block_size_field <= w_data[`MRCS_SIZE_MSB:`MRCS_SIZE_LSB];
      end
      if (wr_aux && w_strb[0]) begin
        pin_function_selector <= w_data[`MRCS_PINSEL_BIT];
        space_selector        <= w_data[`MRCS_SPACE_BIT];
        aux_ready_mode        <= w_data[`MRCS_RDY_BIT];
        aux_wait_field        <= w_data[`MRCS_WS_MSB:`MRCS_WS_LSB];
      end
    end
  end

  // Activation flags, set only, cleared by reset alone
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mid_written  <= 1'b0;
      aux_written  <= 1'b0;
      upper_active <= 1'b0;
    end else begin
      if (wr_mid) begin
        mid_written <= 1'b1;
      end
      if (wr_aux) begin
        aux_written <= 1'b1;
      end
      // An aux register access, read or write, wakes the upper pins
      if (wr_aux || rd_aux) begin
        upper_active <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Size minus one gives the block offset mask in 8K units
  wire [6:0] size_mask = block_size_field - 7'h01;
  wire       size_ok   = (block_size_field != 7'h00) &&
                         ((block_size_field & size_mask) == 7'h00);
  logic [2:0] size_log;
  always_comb begin
    size_log = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (block_size_field[i]) begin
        size_log = 3'(i);
      end
    end
  end
  wire [8:0] quarter_sh = cyc_addr[19:11] >> size_log;
  wire       mid_enable = mid_written && aux_written;
  wire       mid_hit    = mid_enable && size_ok && cyc_mem &&
                          ((cyc_addr[19:13] & ~size_mask) ==
                           (block_base_field & ~size_mask));
  wire [1:0] mid_quarter = quarter_sh[1:0];
  // Peripheral base needs no write here, taken as supplied
  wire [19:0] pcs_off  = cyc_addr - {periph_base, 11'h000};
  wire        pcs5_hit = pcs_off[19:8] == `MRCS_PCS5_SLOT;
  wire        pcs6_hit = pcs_off[19:8] == `MRCS_PCS6_SLOT;
  wire        up_hit   = upper_active && pin_function_selector &&
                         (cyc_mem == space_selector) &&
                         (pcs5_hit || pcs6_hit) && !mid_hit;
  wire        any_hit  = mid_hit || up_hit;

  // ----------------------------------------------------------------
  // Bus cycle sequencing
  // ----------------------------------------------------------------
  // Address is latched at cycle start, selects follow one cycle later
  always_comb begin
    next_state = state;
    case (state)
      mrcs_pkg::CS_IDLE: begin
        if (cpu_cycle_start) begin
          next_state = mrcs_pkg::CS_ADDR;
        end
      end
      mrcs_pkg::CS_ADDR: begin
        next_state = any_hit ? mrcs_pkg::CS_ACTIVE : mrcs_pkg::CS_IDLE;
      end
      mrcs_pkg::CS_ACTIVE: begin
        if (wait_done) begin
          next_state = mrcs_pkg::CS_IDLE;
        end
      end
      default: begin
        next_state = mrcs_pkg::CS_IDLE;
      end
    endcase
  end

  wire enter_act = (state == mrcs_pkg::CS_ADDR) && any_hit;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state      <= mrcs_pkg::CS_IDLE;
      cyc_addr   <= 20'h00000;
      cyc_mem    <= 1'b0;
      cur_is_mid <= 1'b0;
      cur_rmode  <= 1'b0;
      cur_ws     <= 2'h0;
      act_cnt    <= 2'h0;
    end else begin
      state <= next_state;
      if ((state == mrcs_pkg::CS_IDLE) && cpu_cycle_start) begin
        cyc_addr <= cpu_addr;
        cyc_mem  <= cpu_is_mem;
      end
      if (enter_act) begin
        cur_is_mid <= mid_hit;
        cur_rmode  <= mid_hit ? mid_ready_mode : aux_ready_mode;
        cur_ws     <= mid_hit ? mid_wait_field : aux_wait_field;
        act_cnt    <= 2'h0;
      end else if ((state == mrcs_pkg::CS_ACTIVE) && act_cnt != 2'h3) begin
        act_cnt <= act_cnt + 2'h1;
      end
    end
  end

  // Select outputs from flops, all active low
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      midrange_select_outputs_n  <= 4'hF;
      upper_peripheral_selects_n <= 2'h3;
    end else begin
      if (enter_act && mid_hit) begin
        midrange_select_outputs_n <= ~(4'h1 << mid_quarter);
      end else if (wait_done) begin
        midrange_select_outputs_n <= 4'hF;
      end
      if (!upper_active) begin
        upper_peripheral_selects_n <= 2'h3;
      end else if (!pin_function_selector) begin
        if ((state == mrcs_pkg::CS_IDLE) && cpu_cycle_start) begin
          upper_peripheral_selects_n <= {cpu_addr[2], cpu_addr[1]};
        end
      end else if (enter_act && up_hit) begin
        upper_peripheral_selects_n <= {!pcs6_hit, !pcs5_hit};
      end else if (wait_done || (state == mrcs_pkg::CS_IDLE)) begin
        upper_peripheral_selects_n <= 2'h3;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready path
  // ----------------------------------------------------------------
  mrcs_sync3 u_rdy_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin     (ext_ready_pin),
    .level   (ext_ready_s)
  );

  // Trade-off: one shared counter, since only one cycle runs at a time
  mrcs_wait_cnt u_wait (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .load        (enter_act),
    .wait_states (mid_hit ? mid_wait_field : aux_wait_field),
    .ready_mode  (mid_hit ? mid_ready_mode : aux_ready_mode),
    .ext_ready   (ext_ready_s),
    .busy        (state == mrcs_pkg::CS_ACTIVE),
    .done        (wait_done)
  );

  assign cs_claim = state == mrcs_pkg::CS_ACTIVE;
  assign cs_ready = wait_done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_UPPER_HIGH: assert property (
    !upper_active |-> upper_peripheral_selects_n == 2'h3)
    else $error("Upper pins active before aux access");
  AST_MID_OFF: assert property (
    !mid_enable |-> midrange_select_outputs_n == 4'hF)
    else $error("Midrange select before both writes");
  AST_MID_ONE: assert property (
    $onehot0(~midrange_select_outputs_n))
    else $error("More than one midrange select low");
  AST_MID_LATE: assert property (
    (state == mrcs_pkg::CS_IDLE && cpu_cycle_start) |=>
      midrange_select_outputs_n == 4'hF)
    else $error("Midrange select asserted too early");
  AST_MID_WS: assert property (
    (cs_ready && cur_is_mid) |-> act_cnt >= cur_ws)
    else $error("Midrange wait states cut short");
  AST_UP_WS: assert property (
    (cs_ready && !cur_is_mid && cur_rmode) |-> act_cnt == cur_ws)
    else $error("Upper wait count wrong");
  AST_RDY_WAIT: assert property (
    (cs_ready && !cur_rmode) |-> ext_ready_s)
    else $error("Ended without external ready");
  AST_EX_ADDR: assert property (
    (upper_active && !pin_function_selector &&
     state == mrcs_pkg::CS_ACTIVE) |->
      upper_peripheral_selects_n == {cyc_addr[2], cyc_addr[1]})
    else $error("Address pins do not carry a2 a1");
  AST_SPACE: assert property (
    (pin_function_selector && upper_peripheral_selects_n != 2'h3) |->
      cyc_mem == space_selector)
    else $error("Upper select in wrong space");

  COV_MID: cover property (enter_act && mid_hit ##[1:8] cs_ready);
  COV_UP: cover property (enter_act && up_hit ##[1:8] cs_ready);
  COV_ADDR_MODE: cover property (
    upper_active && !pin_function_selector && cpu_cycle_start);

endmodule : mrcs_top
`default_nettype wire

// ### sim/mrcs_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// External device: answers with ready after a set delay
// ----------------------------------------------------------------
module mrcs_ext_dev (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [3:0] mid_n,
  input  wire logic [1:0] up_n,
  input  wire logic [3:0] delay,
  output var  logic       ext_ready
);
  logic [3:0] cnt;
  logic       sel;
  // Any select low means this device is addressed
  assign sel = !(&mid_n) || !(&up_n);
  // Ready only after the delay; the flop drives it low otherwise
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt       <= 4'h0;
      ext_ready <= 1'b0;
    end else begin
      cnt       <= sel ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
      ext_ready <= sel && (cnt >= delay);
    end
  end
endmodule : mrcs_ext_dev
`default_nettype wire

// ### sim/mrcs_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module mrcs_top_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [19:0] cpu_addr = 20'h0;
  logic        cpu_cycle_start = 0, cpu_is_mem = 0;
  logic [8:0]  periph_base = 9'h010;
  logic        ext_ready_pin, cs_claim, cs_ready;
  logic [3:0]  midrange_select_outputs_n, dly = 4'h0;
  logic [1:0]  upper_peripheral_selects_n;
  logic [32:0] expq[$];
  logic [15:0] cnt = 16'h0;
  int          err_count = 0, n_tests = 0, tick = 0;

  mrcs_top u_mrcs_top (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_addr,
    .cpu_cycle_start, .cpu_is_mem, .periph_base, .ext_ready_pin,
    .midrange_select_outputs_n, .upper_peripheral_selects_n,
    .cs_claim, .cs_ready);
  mrcs_ext_dev u_mrcs_ext_dev (.clk_sys, .reset,
    .mid_n(midrange_select_outputs_n), .up_n(upper_peripheral_selects_n),
    .delay(dly), .ext_ready(ext_ready_pin));

  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Comparison and closing report
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Oldest note against a seen result; min-mode notes bound the wait
  task automatic take(input logic [31:0] s);
    logic [32:0] e;
    e = (expq.size() == 0) ? 33'h0FFFFFFFF : expq.pop_front();
    if (e[32] && s[15:0] >= e[15:0]) s[15:0] = e[15:0];
    check(s, e[31:0]);
  endtask : take

  // Sampled mid-cycle: settled values that the next edge will take
  always @(negedge clk_sys) begin
    if (!reset && s_axi_bvalid && s_axi_bready) take({30'h0, s_axi_bresp});
    if (!reset && s_axi_rvalid && s_axi_rready)
      take({s_axi_rresp, 14'h0, s_axi_rdata[15:0]});
    if (!reset && cs_ready) take({10'h0, midrange_select_outputs_n,
                                  upper_peripheral_selects_n, cnt + 16'h1});
    cnt <= cs_claim ? cnt + 16'h1 : 16'h0;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    tick++;
    if (tick == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Bus drivers
  // ----------------------------------------------------------------
  task automatic axw(input logic [11:0] a, input logic [15:0] d,
                     input logic [1:0] r);
    logic ta, tw, tb;
    expq.push_back({31'h0, r});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'($urandom), d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [17:0] e);
    logic ta, tv;
    expq.push_back({1'b0, e[17:16], 14'h0, e[15:0]});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tv);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axr

  // One bus cycle; sel is {midrange, upper}, c the select-low cycles
  task automatic cyc(input logic [19:0] a, input logic m, input logic hit,
                     input logic [5:0] sel, input logic [15:0] c,
                     input logic mn);
    if (hit) expq.push_back({mn, 10'h0, sel, c});
    cpu_addr        <= a;
    cpu_is_mem      <= m;
    cpu_cycle_start <= 1'b1;
    @(posedge clk_sys);
    cpu_cycle_start <= 1'b0;
    repeat (3) @(posedge clk_sys);
    do @(negedge clk_sys); while (cs_claim);
    repeat (2) @(posedge clk_sys);
  endtask : cyc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h91C4));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    axr(12'h2A8, {2'b00, 16'h0003});
    axr(12'h298, {2'b00, 16'h01F8});
    axr(12'h2A0, {2'b00, 16'h8038});
    axr(12'h2B0, {2'b10, 16'h0000});
    axw(12'h2B0, 16'h1234, 2'b10);
    cyc(20'h08500, 1, 0, 6'h0, 16'h0, 0);
    axw(12'h2A0, 16'h04C6, 2'b00);
    axr(12'h2A0, {2'b00, 16'h84FE});
    cyc(20'h08500 + 20'($urandom & 32'hFF), 1, 1, 6'h3E, 3, 0);
    cyc(20'h086FF, 1, 1, 6'h3D, 3, 0);
    cyc(20'h08500, 0, 0, 6'h0, 16'h0, 0);
    cyc(20'h20000, 1, 0, 6'h0, 16'h0, 0);
    axw(12'h298, 16'h2005, 2'b00);
    axr(12'h298, {2'b00, 16'h21FD});
    for (int q = 0; q < 4; q++)
      cyc(20'h20000 + 20'(q * 32'h2000) + 20'($urandom & 32'h1FFF), 1, 1,
          {~(4'h1 << q), 2'b11}, 2, 0);
    cyc(20'h28000, 1, 0, 6'h0, 16'h0, 0);
    cyc(20'h20000, 0, 0, 6'h0, 16'h0, 0);
    dly <= 4'h8;
    axw(12'h2A0, 16'h04C2, 2'b00);
    cyc(20'h08600, 1, 1, 6'h3D, 8, 1);
    axw(12'h298, 16'h0007, 2'b00);
    for (int i = 0; i < 7; i++) begin
      axw(12'h2A0, 16'((32'h1 << i) << 8) | 16'h0080, 2'b00);
      cyc(20'((32'h2000 << i) - 2), 1, 1, 6'h1F, 4, 0);
    end
    dly <= 4'h5;
    axw(12'h298, 16'h0000, 2'b00);
    cyc(20'h7FFFE, 1, 1, 6'h1F, 5, 1);
    axw(12'h2A0, 16'h4000, 2'b00);
    cyc(20'h00002, 1, 1, 6'h39, 5, 1);
    cyc(20'h00004, 0, 0, 6'h0, 16'h0, 0);
    axw(12'h2A8, 16'hFFFF, 2'b00);
    axr(12'h2A8, {2'b00, 16'h0039});
    check({30'h0, upper_peripheral_selects_n}, 32'h2);
    check(32'(expq.size()), 32'h0);
    summarize();
  end
endmodule : mrcs_top_test
`default_nettype wire
